// file: inc/tc_consts.svh
// Constants of the 16-bit timer/counter: register indices, fields, reset values, timing.
// Assumes one 20 MHz core clock and a classic Wishbone slave port with 32-bit data.
// What this block does
// - Control bit 3 enables low-power oscillator.
// - Enabled oscillator overrides port direction bits 1:0.
// - Oscillator and external counting continue during sleep.
// - Source clear counts instruction cycles; set, edges.
// - Counter counts only while on bit set.
// - Count readable, writable at 0Eh and 0Fh.
// - Count runs 0000h to FFFFh, then wraps.
// - Wrap sets sticky overflow flag bit 0.
// - Interrupt only when enable bit 0 set.
// - Special event trigger mode 1011 zeroes count.
// - Trigger reset never sets overflow flag.
// - Count write beats simultaneous trigger reset.
// - Compare value acts as counter period only in trigger mode 1011.
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH
`define TC_IDX_GIC      8'h0B
`define TC_IDX_FLAGS    8'h0C
`define TC_IDX_CNTL     8'h0E
`define TC_IDX_CNTH     8'h0F
`define TC_IDX_CTRL     8'h10
`define TC_IDX_IEN      8'h8C
`define TC_CTRL_MASK    8'h3F
`define TC_CTRL_RST     8'h00
`define TC_BYTE_RST     8'h00
`define TC_OVF_BIT      0
`define TC_CNT_MAX      16'hFFFF
`define TC_CNT_ZERO     16'h0000
`define TC_MODE_SPECIAL 4'hB
`define TC_CLK_HZ       20000000
`define TC_INSTR_HZ     5000000
`define TC_INSTR_CLKS   (`TC_CLK_HZ / `TC_INSTR_HZ)
`endif

// file: inc/tc_pkg.sv
// Types shared by the timer/counter design.
// Assumes the constants header is compiled alongside.
package tc_pkg;
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] input_prescale_select;
    logic       low_power_osc_enable;
    logic       external_sync_disable;
    logic       count_source_select;
    logic       counter_on;
  } tc_ctrl_s;

  typedef struct packed {
    logic [1:0] dir;
    logic [1:0] dout;
  } tc_port_s;

  typedef enum logic [1:0] {
    TC_BUS_IDLE = 2'b01,
    TC_BUS_ACK  = 2'b10
  } tc_bus_e;
endpackage

// file: src/tc_timer.sv
// 16-bit timer/counter with prescaler, low-power oscillator pins and overflow interrupt.
// Assumes a classic Wishbone master on the core clock and raw pins from outside.
`include "tc_consts.svh"

module tc_timer (
  // Clock and resets
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               other_rst_i,
  // Wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [9:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // Core state and compare unit
  input  wire logic               sleep_i,
  input  wire logic [3:0]         compare_unit_mode_i,
  input  wire logic [15:0]        compare_value_pair_i,
  // Shared port pins: bit 0 is the oscillator output pin, bit 1 its input pin
  input  wire tc_pkg::tc_port_s   port_i,
  input  wire logic [1:0]         pin_i,
  output logic      [1:0]         pin_o,
  output logic      [1:0]         pin_oe_o,
  // Interrupt
  output logic                    irq_o
);
  import tc_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  tc_ctrl_s   ctrl_r;
  logic [7:0] gic_r;
  logic       ovf_r;
  logic       ien_r;
  logic [15:0] cnt_r;
  logic [2:0] pre_r;
  logic [1:0] div_r;
  tc_bus_e    bus_r;
  logic [31:0] dat_r;
  logic [1:0] pin_r;
  logic       s1_r;
  logic       s2_r;
  logic       s3_r;
  logic       lvl_r;
  logic       async_r;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        req      = cyc_i & stb_i;
  wire        acking   = (bus_r == TC_BUS_ACK);
  wire        wr       = req & we_i & acking & sel_i[0];
  wire [7:0]  idx      = adr_i[9:2];
  wire [7:0]  wbyte    = dat_i[7:0];
  wire        wr_gic   = wr & (idx == `TC_IDX_GIC);
  wire        wr_flags = wr & (idx == `TC_IDX_FLAGS);
  wire        wr_lo    = wr & (idx == `TC_IDX_CNTL);
  wire        wr_hi    = wr & (idx == `TC_IDX_CNTH);
  wire        wr_ctrl  = wr & (idx == `TC_IDX_CTRL);
  wire        wr_ien   = wr & (idx == `TC_IDX_IEN);
  wire        wr_cnt   = wr_lo | wr_hi;

  logic [7:0] rbyte;
  always_comb
  begin
    case (idx)
      `TC_IDX_GIC:   rbyte = gic_r;
      `TC_IDX_FLAGS: rbyte = {7'h00, ovf_r};
      `TC_IDX_CNTL:  rbyte = cnt_r[7:0];
      `TC_IDX_CNTH:  rbyte = cnt_r[15:8];
      `TC_IDX_CTRL:  rbyte = ctrl_r & `TC_CTRL_MASK;
      `TC_IDX_IEN:   rbyte = {7'h00, ien_r};
      default:       rbyte = 8'h00;
    endcase
  end

  // Every access is acknowledged one cycle after the request; unmapped ones read zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_r <= TC_BUS_IDLE;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      case (bus_r)
        TC_BUS_IDLE:
        begin
          if (req)
          begin
            bus_r <= TC_BUS_ACK;
            dat_r <= {24'h00_0000, rbyte};
          end
        end
        TC_BUS_ACK: bus_r <= TC_BUS_IDLE;
        default:    bus_r <= TC_BUS_IDLE;
      endcase
    end
  end

  assign ack_o = acking & req;
  assign dat_o = dat_r;

  // ****************************************
  // Control registers
  // ****************************************
  // Only power-on reset clears control; the other resets leave it alone.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= `TC_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= wbyte & `TC_CTRL_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i | other_rst_i)
    begin
      gic_r <= `TC_BYTE_RST;
      ien_r <= 1'b0;
    end
    else
    begin
      if (wr_gic)
        gic_r <= wbyte;
      if (wr_ien)
        ien_r <= wbyte[`TC_OVF_BIT];
    end
  end

  // ****************************************
  // Count clock selection
  // ****************************************
  // With the oscillator on, the clock comes from its input pin instead of the plain input.
  wire raw_clk = ctrl_r.low_power_osc_enable ? pin_i[1] : pin_i[0];

  // The filtered level only follows once the last two stages agree.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      lvl_r   <= 1'b0;
      async_r <= 1'b0;
    end
    else
    begin
      s1_r    <= raw_clk;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      async_r <= s2_r;
      if (s2_r == s3_r)
        lvl_r <= s3_r;
    end
  end

  // Without synchronization the edge is taken one stage earlier and unfiltered,
  // so a trigger reset may race it; software avoids that mode for triggers.
  wire sync_rise  = s2_r & s3_r & ~lvl_r;
  wire async_rise = s2_r & ~async_r;
  wire ext_rise   = ctrl_r.external_sync_disable ? async_rise : sync_rise;

  // Instruction cycles stop in sleep; external edges keep counting.
  wire instr_tick = (div_r == 2'(`TC_INSTR_CLKS - 1)) & ~sleep_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i | sleep_i)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end

  wire src_evt = ctrl_r.counter_on
               & (ctrl_r.count_source_select ? ext_rise : instr_tick);

  // ****************************************
  // Prescaler
  // ****************************************
  logic [2:0] pre_mask;
  always_comb
  begin
    case (ctrl_r.input_prescale_select)
      2'b11:   pre_mask = 3'h7;
      2'b10:   pre_mask = 3'h3;
      2'b01:   pre_mask = 3'h1;
      default: pre_mask = 3'h0;
    endcase
  end

  wire pre_done = ((pre_r & pre_mask) == pre_mask);
  wire cnt_evt  = src_evt & pre_done;

  // A count write also restarts the prescaler so the new value gets a full period.
  always_ff @(posedge clk_i)
  begin
    if (rst_i | other_rst_i | wr_cnt)
      pre_r <= 3'h0;
    else if (src_evt)
      pre_r <= pre_done ? 3'h0 : pre_r + 3'h1;
  end

  // ****************************************
  // Counter
  // ****************************************
  wire trig     = (compare_unit_mode_i == `TC_MODE_SPECIAL)
                & (cnt_r == compare_value_pair_i);
  wire wrap     = cnt_evt & (cnt_r == `TC_CNT_MAX) & ~trig & ~wr_cnt;

  logic [15:0] cnt_nxt;
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (wr_cnt)
    begin
      if (wr_lo)
        cnt_nxt[7:0] = wbyte;
      if (wr_hi)
        cnt_nxt[15:8] = wbyte;
    end
    else if (trig)
      cnt_nxt = `TC_CNT_ZERO;
    else if (cnt_evt)
      cnt_nxt = cnt_r + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_r <= `TC_CNT_ZERO;
    else
      cnt_r <= cnt_nxt;
  end

  // ****************************************
  // Overflow flag and interrupt
  // ****************************************
  // A wrap in the same cycle as a one-write keeps the flag set.
  always_ff @(posedge clk_i)
  begin
    if (rst_i | other_rst_i)
      ovf_r <= 1'b0;
    else if (wrap)
      ovf_r <= 1'b1;
    else if (wr_flags & wbyte[`TC_OVF_BIT])
      ovf_r <= 1'b0;
  end

  assign irq_o = ovf_r & ien_r;

  // ****************************************
  // Oscillator pins
  // ****************************************
  // The amplifier output inverts the oscillator input; it keeps going in sleep.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_r <= 2'h0;
    else if (ctrl_r.low_power_osc_enable)
      pin_r <= {port_i.dout[1], ~s2_r};
    else
      pin_r <= port_i.dout;
  end

  assign pin_o    = pin_r;
  assign pin_oe_o = ctrl_r.low_power_osc_enable ? 2'b01 : ~port_i.dir;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_quiet;
    !wr_cnt && !trig;
  endsequence

  sequence seq_timer_tick;
    ctrl_r.counter_on && !ctrl_r.count_source_select && instr_tick && pre_mask == 3'h0;
  endsequence

  AST_TIMER_TICK: assert property ((seq_timer_tick and seq_quiet) |=>
    cnt_r == $past(cnt_r) + 16'h0001)
    else $error("Timer did not advance on an instruction cycle.");

  AST_DIV8: assert property ((src_evt && pre_mask == 3'h7 && pre_r != 3'h7)
    ##0 seq_quiet |=> $stable(cnt_r))
    else $error("Prescaler let an event through early.");

  AST_DIV_NONE: assert property ((cnt_evt && pre_mask == 3'h0) ##0 seq_quiet
    |=> cnt_r != $past(cnt_r))
    else $error("Undivided event did not advance the count.");

  AST_OSC_PINS: assert property (ctrl_r.low_power_osc_enable |-> pin_oe_o == 2'b01)
    else $error("Oscillator pins follow port direction.");

  AST_SLEEP_OSC: assert property (sleep_i && ctrl_r.low_power_osc_enable
    ##1 ctrl_r.low_power_osc_enable |-> pin_o[0] == !$past(s2_r))
    else $error("Oscillator amplifier stopped in sleep.");

  AST_OFF: assert property (!ctrl_r.counter_on ##0 seq_quiet |=> $stable(cnt_r))
    else $error("Counter moved while off.");

  AST_WRAP: assert property (wrap |=> cnt_r == `TC_CNT_ZERO && ovf_r)
    else $error("Wrap did not clear count and set flag.");

  // The other reset may also clear the flag, so it is left out of the antecedent.
  AST_FLAG_STICKY: assert property (ovf_r && !other_rst_i
    && !(wr_flags && wbyte[`TC_OVF_BIT]) |=> ovf_r)
    else $error("Overflow flag dropped without a clear.");

  AST_IRQ_GATE: assert property (!ien_r |-> !irq_o)
    else $error("Interrupt raised while disabled.");

  // A clear of the flag may share the cycle with a trigger; only a set is forbidden.
  AST_TRIG: assert property (trig && !wr_cnt |=> cnt_r == `TC_CNT_ZERO &&
    !$rose(ovf_r))
    else $error("Trigger did not zero the count cleanly.");

  AST_WRITE_WINS: assert property (trig && wr_lo |=> cnt_r[7:0] == $past(dat_i[7:0]))
    else $error("Trigger beat a count write.");

  AST_CTRL_TOP: assert property (ack_o && !we_i && idx == `TC_IDX_CTRL
    |-> dat_o[7:6] == 2'b00)
    else $error("Control top bits read non-zero.");

endmodule

// file: testbench/tb_sixteen_bit_timer_counter.sv
// Self-checking bench of the 16-bit timer/counter over classic Wishbone.
// Assumes the design header and package are compiled alongside.
`include "tc_consts.svh"
module tb_sixteen_bit_timer_counter;
  timeunit 1ns;
  timeprecision 1ns;
  import tc_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} tc_row_s;
  logic        clk_i = 1'b0;
  logic        rst_i, other_rst_i, cyc_i, stb_i, we_i, sleep_i, ack_o, irq_o, xclk;
  logic [9:0]  adr_i;
  logic [3:0]  sel_i, mode;
  logic [31:0] dat_i, dat_o;
  logic [15:0] cmp, v, w;
  logic [1:0]  pin_o, pin_oe_o, pin_i;
  tc_port_s    port;
  int          err_count, check_count;
  tc_row_s     rows [7] = '{'{8'h10, 8'hFF, 8'h3F}, '{8'h10, 8'h00, 8'h00},
    '{8'h8C, 8'h01, 8'h01}, '{8'h8C, 8'h00, 8'h00}, '{8'h0B, 8'hA5, 8'hA5},
    '{8'h0E, 8'h5A, 8'h5A}, '{8'h20, 8'h77, 8'h00}};
  always #25 clk_i = ~clk_i;
  // Each pin carries the design's drive while enabled, otherwise the far side.
  assign pin_i[0] = pin_oe_o[0] ? pin_o[0] : xclk;
  assign pin_i[1] = pin_oe_o[1] ? pin_o[1] : xclk;
  tc_ext_osc osc (.clk_o(xclk));
  tc_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .other_rst_i(other_rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .sleep_i(sleep_i), .compare_unit_mode_i(mode),
    .compare_value_pair_i(cmp), .port_i(port), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .irq_o(irq_o));

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // The request is held until ack is seen high at a rising edge, then released.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, wd};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 16)
    begin
      @(posedge clk_i);
      n++;
    end
    // Read data is taken at the very edge at which ack is seen, and released there.
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (n >= 16)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk({8'h00, x}, {8'h00, exp});
  endtask

  task automatic rd16(output logic [15:0] c);
    bus(1'b0, `TC_IDX_CNTL, 8'h00, c[7:0]);
    bus(1'b0, `TC_IDX_CNTH, 8'h00, c[15:8]);
  endtask

  task automatic clr_cnt();
    wr(`TC_IDX_CNTH, 8'h00);
    wr(`TC_IDX_CNTL, 8'h00);
  endtask

  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, other_rst_i, sleep_i} = 6'b100000;
    {adr_i, dat_i, sel_i, mode, cmp, port} = {10'h000, 32'h0, 4'h1, 4'h0, 16'hFFFF, 4'hC};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`TC_IDX_CTRL, `TC_CTRL_RST);
    rdc(`TC_IDX_FLAGS, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].exp);
    end
    $display("test register rows done");
    for (int c = 0; c < 4; c++)
    begin
      clr_cnt();
      wr(`TC_IDX_CTRL, {2'b00, c[1:0], 4'h1});
      repeat (640) @(posedge clk_i);
      wr(`TC_IDX_CTRL, {2'b00, c[1:0], 4'h0});
      rd16(v);
      chk_rng(v, (160 >> c) - 1, (160 >> c) + 2);
    end
    repeat (100) @(posedge clk_i);
    rd16(w);
    chk(w, v);
    $display("test prescale done");
    wr(`TC_IDX_CNTH, 8'hFF);
    wr(`TC_IDX_CNTL, 8'hF8);
    wr(`TC_IDX_CTRL, 8'h01);
    repeat (100) @(posedge clk_i);
    wr(`TC_IDX_CTRL, 8'h00);
    rdc(`TC_IDX_CNTH, 8'h00);
    rdc(`TC_IDX_FLAGS, 8'h01);
    chk(irq_o, 1'b0);
    wr(`TC_IDX_IEN, 8'h01);
    @(negedge clk_i);
    chk(irq_o, 1'b1);
    wr(`TC_IDX_FLAGS, 8'h01);
    rdc(`TC_IDX_FLAGS, 8'h00);
    chk(irq_o, 1'b0);
    $display("test overflow done");
    clr_cnt();
    cmp  <= 16'h0010;
    mode <= `TC_MODE_SPECIAL;
    wr(`TC_IDX_CTRL, 8'h01);
    repeat (1000) @(posedge clk_i);
    wr(`TC_IDX_CTRL, 8'h00);
    rd16(v);
    chk_rng(v, 0, 16);
    rdc(`TC_IDX_FLAGS, 8'h00);
    // With the compare value at zero the trigger fires on the very edge of the write.
    cmp <= 16'h0000;
    clr_cnt();
    wr(`TC_IDX_CNTL, 8'h33);
    rdc(`TC_IDX_CNTL, 8'h33);
    mode <= 4'h0;
    $display("test trigger done");
    wr(`TC_IDX_CTRL, 8'h34);
    other_rst_i <= 1'b1;
    @(posedge clk_i);
    other_rst_i <= 1'b0;
    rdc(`TC_IDX_CTRL, 8'h34);
    rdc(`TC_IDX_CNTL, 8'h33);
    $display("test other reset done");
    clr_cnt();
    wr(`TC_IDX_CTRL, 8'h03);
    osc.burst(10);
    repeat (10) @(posedge clk_i);
    wr(`TC_IDX_CTRL, 8'h02);
    rd16(v);
    chk(v, 16'h000A);
    wr(`TC_IDX_CTRL, 8'h07);
    osc.burst(10);
    repeat (10) @(posedge clk_i);
    wr(`TC_IDX_CTRL, 8'h06);
    rd16(v);
    chk(v, 16'h0014);
    port <= 4'h0;
    wr(`TC_IDX_CTRL, 8'h0B);
    @(negedge clk_i);
    chk(pin_oe_o, 2'b01);
    repeat (200) @(posedge clk_i);
    chk(pin_o, 2'b01);
    sleep_i <= 1'b1;
    osc.burst(10);
    repeat (10) @(posedge clk_i);
    chk(pin_o, 2'b01);
    sleep_i <= 1'b0;
    wr(`TC_IDX_CTRL, 8'h0A);
    rd16(v);
    chk_rng(v, 29, 31);
    $display("test external clock done");
    print_verdict();
  end
endmodule

// file: testbench/tc_ext_osc.sv
// Model of the far side: an external clock source or low-power crystal.
// Assumes the bench calls burst() and routes the output onto the shared pins.
module tc_ext_osc #(
  parameter int HALF_NS = 220
) (
  output logic clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The source stands still low between bursts, like a stopped crystal.
  initial clk_o = 1'b0;
  // Runs regardless of the core's sleep state; each period has one rising edge.
  task automatic burst(input int n);
    repeat (n)
    begin
      #HALF_NS clk_o = 1'b1;
      #HALF_NS clk_o = 1'b0;
    end
  endtask
endmodule
